// ---- verilog/pmu_status_readback_regs.svh ----
// register offsets, field positions and reset values of the status readback block
`ifndef PMU_STATUS_READBACK_REGS_SVH
`define PMU_STATUS_READBACK_REGS_SVH

// byte offsets on the register port
`define REG_CH_CTRL0      8'h00
`define REG_CH_CTRL3      8'h0C
`define REG_SYS_CTRL      8'h10
`define REG_RB_SELECT     8'h14
`define REG_RB_DATA       8'h18
`define REG_IRQ_STATUS    8'h1C
`define REG_IRQ_MASK      8'h20

// readback word fields
`define WORD_TYPE_HI      23
`define WORD_TYPE_LO      22
`define MEAS_SEL_HI       14
`define MEAS_SEL_LO       13
`define FORCE_IN_BIT      12
`define SYS_FORCE_BIT     11
`define SYS_SENSE_BIT     10
`define CLAMP_EN_BIT      9
`define CMP_OUT_EN_BIT    8
`define CMP_VOLT_BIT      7
`define STICKY_TEMP_BIT   6
`define LIVE_TEMP_BIT     5
`define CLEAR_BIT         6
`define CMP_FIELD_TOP     21
`define ALM_STICKY_BIT    21
`define ALM_LIVE_BIT      20
`define ALM_GUARD_TOP     19
`define ALM_CLAMP_TOP     11

// interrupt status bits
`define IRQ_TEMP_BIT      0
`define IRQ_CMP_BIT       1
`define IRQ_ALARM_BIT     2
`define IRQ_WIDTH         3

// reset values
`define MEAS_SEL_RESET    2'h3
`define RB_SELECT_RESET   4'h0

`endif

// ---- verilog/pmu_status_readback_pkg.sv ----
// types shared by the status readback block
package pmu_status_readback_pkg;

    // word type carried in the two top bits of a readback word
    typedef enum logic [1:0] {
        WT_CHANNEL    = 2'b00,
        WT_COMPARATOR = 2'b01,
        WT_RESERVED   = 2'b10,
        WT_ALARM      = 2'b11
    } word_type_e;

    // measure output connection codes
    typedef enum logic [1:0] {
        MS_ISENSE = 2'b00,
        MS_VSENSE = 2'b01,
        MS_TEMP   = 2'b10,
        MS_HIGHZ  = 2'b11
    } measure_sel_e;

    typedef logic [23:0] rb_word_t;

endpackage

// ---- verilog/pmu_status_readback.sv ----
// status readback register bank of a four-channel measurement unit
//
// Contract
// - word type 00 returns the status of one selected channel only.
// - measure-select bits 14:13 give 00 current, 01 voltage, 10 temperature sensor.
// - measure-select code 11 means measure output high impedance, switch open.
// - bit 12 is force input source, 0 ground, 1 level converter.
// - bits 11 and 10 show system force and sense lines switched in.
// - bit 9 reports channel current clamp enable.
// - clamp enable reads the last write, system-wide or per-channel.
// - bit 8 reports channel comparator output enable.
// - comparator output enable reads the last write, system-wide or per-channel.
// - bit 7 reads 1 for compare voltage, 0 for compare current.
// - bit 6 sticky overtemperature flag, bit 5 live overtemperature level.
// - sticky overtemperature stays set until host writes one to bit 6.
// - comparator word is read-only, word type 01.
// - comparator bits 21:14 low/high pairs from channel 0; 13:0 zero.
// - each comparator bit follows its comparator output level.
// - alarm word is read-only, reports temperature, clamp and guard alarms.
// - temperature alarm appears in every channel readback word too.
`include "pmu_status_readback_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module pmu_status_readback (
    input  wire logic        CLK,                    // system clock, 40 MHz
    input  wire logic        RST_N,                  // asynchronous reset, active low
    input  wire logic [7:0]  ADDR,                   // register byte address
    input  wire logic [31:0] WDATA,                  // write data
    input  wire logic        WR,                     // write strobe
    input  wire logic        RD,                     // read strobe
    output logic      [31:0] RDATA,                  // read data, cycle after RD
    input  wire logic [3:0]  CMP_LOW,                // low comparator pins, async
    input  wire logic [3:0]  CMP_HIGH,               // high comparator pins, async
    input  wire logic        OVERTEMP,               // junction over alarm level, async
    input  wire logic [3:0]  CLAMP_ALARM,            // per-channel clamp alarm, async
    input  wire logic [3:0]  GUARD_ALARM,            // per-channel guard alarm, async
    output logic             IRQ,                    // level interrupt, active high
    output logic      [3:0]  FORCE_INPUT_SOURCE,     // 1 = force input from converter
    output logic      [3:0]  CURRENT_CLAMP_ENABLED,  // clamp enable per channel
    output logic      [3:0]  COMPARATOR_OUT_ENABLED  // comparator output enable per channel
);

    localparam int SYNC_W = 17;

    // synchroniser stages; the first is read by the second only
    logic [SYNC_W-1:0] sync_meta;
    logic [SYNC_W-1:0] sync_q;
    logic [3:0]        cmp_low;
    logic [3:0]        cmp_high;
    logic [3:0]        clamp_alarm;
    logic [3:0]        guard_alarm;
    logic              live_overtemp_flag;

    // channel control state
    logic [1:0]        measure_select [4];
    logic [3:0]        system_force_switched;
    logic [3:0]        system_sense_switched;
    logic [3:0]        compare_voltage;
    logic [3:0]        force_input_source;
    logic [3:0]        current_clamp_enabled;
    logic [3:0]        comparator_out_enabled;

    // alarm and readback state
    logic              sticky_overtemp_flag;
    logic [3:0]        sticky_clamp;
    logic [3:0]        sticky_guard;
    logic [3:0]        rb_select;
    logic [7:0]        cmp_prev;
    logic [`IRQ_WIDTH-1:0] irq_status;
    logic [`IRQ_WIDTH-1:0] irq_mask;
    logic              temp_prev;
    logic [7:0]        alarm_prev;

    // decoded strobes and formed words
    logic              ch_write;
    logic [1:0]        ch_index;
    logic              sys_write;
    logic              clear_write;
    pmu_status_readback_pkg::rb_word_t chan_word;
    pmu_status_readback_pkg::rb_word_t cmp_word;
    pmu_status_readback_pkg::rb_word_t alarm_word;
    pmu_status_readback_pkg::rb_word_t rb_word;
    logic [31:0]       next_rdata;
    logic [`IRQ_WIDTH-1:0] irq_event;

    // two flops on every pin input before any logic sees it
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sync_meta <= '0;
            sync_q    <= '0;
        end else begin
            sync_meta <= {OVERTEMP, GUARD_ALARM, CLAMP_ALARM, CMP_HIGH, CMP_LOW};
            sync_q    <= sync_meta;
        end
    end

    assign cmp_low            = sync_q[3:0];
    assign cmp_high           = sync_q[7:4];
    assign clamp_alarm        = sync_q[11:8];
    assign guard_alarm        = sync_q[15:12];
    assign live_overtemp_flag = sync_q[16];

    // address decode; channel registers sit at four consecutive words
    // the channel block starts at offset zero, so only its upper bound needs a test
    assign ch_write    = WR && (ADDR <= `REG_CH_CTRL3) && (ADDR[1:0] == 2'h0);
    assign ch_index    = ADDR[3:2];
    assign sys_write   = WR && (ADDR == `REG_SYS_CTRL);
    assign clear_write = ch_write && WDATA[`CLEAR_BIT];

    // per-channel fields written only through the channel register
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int i = 0; i < 4; i++) begin
                measure_select[i] <= `MEAS_SEL_RESET;
            end
            force_input_source    <= '0;
            system_force_switched <= '0;
            system_sense_switched <= '0;
            compare_voltage       <= '0;
        end else if (ch_write) begin
            measure_select[ch_index]        <= WDATA[`MEAS_SEL_HI:`MEAS_SEL_LO];
            force_input_source[ch_index]    <= WDATA[`FORCE_IN_BIT];
            system_force_switched[ch_index] <= WDATA[`SYS_FORCE_BIT];
            system_sense_switched[ch_index] <= WDATA[`SYS_SENSE_BIT];
            compare_voltage[ch_index]       <= WDATA[`CMP_VOLT_BIT];
        end
    end

    // clamp and comparator enables: the later of system or channel write wins
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            current_clamp_enabled  <= '0;
            comparator_out_enabled <= '0;
        end else if (sys_write) begin
            current_clamp_enabled  <= {4{WDATA[`CLAMP_EN_BIT]}};
            comparator_out_enabled <= {4{WDATA[`CMP_OUT_EN_BIT]}};
        end else if (ch_write) begin
            current_clamp_enabled[ch_index]  <= WDATA[`CLAMP_EN_BIT];
            comparator_out_enabled[ch_index] <= WDATA[`CMP_OUT_EN_BIT];
        end
    end

    // sticky alarms; a set in the clearing cycle wins so no event is lost
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sticky_overtemp_flag <= 1'b0;
            sticky_clamp         <= '0;
            sticky_guard         <= '0;
        end else begin
            sticky_overtemp_flag <= live_overtemp_flag
                                    || (sticky_overtemp_flag && !clear_write);
            sticky_clamp <= clamp_alarm | (sticky_clamp & {4{!clear_write}});
            sticky_guard <= guard_alarm | (sticky_guard & {4{!clear_write}});
        end
    end

    // readback selector: word type and channel
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rb_select <= `RB_SELECT_RESET;
        end else if (WR && ADDR == `REG_RB_SELECT) begin
            rb_select <= {WDATA[`WORD_TYPE_HI:`WORD_TYPE_LO], WDATA[1:0]};
        end
    end

    // channel word for the one selected channel
    always_comb begin
        chan_word = '0;
        chan_word[`WORD_TYPE_HI:`WORD_TYPE_LO] = pmu_status_readback_pkg::WT_CHANNEL;
        chan_word[`MEAS_SEL_HI:`MEAS_SEL_LO] = measure_select[rb_select[1:0]];
        chan_word[`FORCE_IN_BIT]   = force_input_source[rb_select[1:0]];
        chan_word[`SYS_FORCE_BIT]  = system_force_switched[rb_select[1:0]];
        chan_word[`SYS_SENSE_BIT]  = system_sense_switched[rb_select[1:0]];
        chan_word[`CLAMP_EN_BIT]   = current_clamp_enabled[rb_select[1:0]];
        chan_word[`CMP_OUT_EN_BIT] = comparator_out_enabled[rb_select[1:0]];
        chan_word[`CMP_VOLT_BIT]   = compare_voltage[rb_select[1:0]];
        chan_word[`STICKY_TEMP_BIT] = sticky_overtemp_flag;
        chan_word[`LIVE_TEMP_BIT]   = live_overtemp_flag;
    end

    // comparator word built from live pin state, alarm word from live and sticky state
    always_comb begin
        cmp_word   = '0;
        alarm_word = '0;
        cmp_word[`WORD_TYPE_HI:`WORD_TYPE_LO]   = pmu_status_readback_pkg::WT_COMPARATOR;
        alarm_word[`WORD_TYPE_HI:`WORD_TYPE_LO] = pmu_status_readback_pkg::WT_ALARM;
        alarm_word[`ALM_STICKY_BIT] = sticky_overtemp_flag;
        alarm_word[`ALM_LIVE_BIT]   = live_overtemp_flag;
        for (int i = 0; i < 4; i++) begin
            cmp_word[`CMP_FIELD_TOP - 2*i]     = cmp_low[i];
            cmp_word[`CMP_FIELD_TOP - 2*i - 1] = cmp_high[i];
            alarm_word[`ALM_GUARD_TOP - 2*i]     = sticky_guard[i];
            alarm_word[`ALM_GUARD_TOP - 2*i - 1] = guard_alarm[i];
            alarm_word[`ALM_CLAMP_TOP - 2*i]     = sticky_clamp[i];
            alarm_word[`ALM_CLAMP_TOP - 2*i - 1] = clamp_alarm[i];
        end
    end

    // word type picks the readback word; the undefined type reads its type only
    always_comb begin
        unique case (pmu_status_readback_pkg::word_type_e'(rb_select[3:2]))
            pmu_status_readback_pkg::WT_CHANNEL:    rb_word = chan_word;
            pmu_status_readback_pkg::WT_COMPARATOR: rb_word = cmp_word;
            pmu_status_readback_pkg::WT_ALARM:      rb_word = alarm_word;
            pmu_status_readback_pkg::WT_RESERVED:   rb_word = {2'h2, 22'h000000};
        endcase
    end

    // read mux; readback words have no write path at all
    always_comb begin
        next_rdata = 32'h00000000;
        if (RD) begin
            if (ADDR == `REG_RB_DATA) begin
                next_rdata = {8'h00, rb_word};
            end else if (ADDR == `REG_RB_SELECT) begin
                next_rdata = {8'h00, rb_select[3:2], 20'h00000, rb_select[1:0]};
            end else if (ADDR == `REG_IRQ_STATUS) begin
                next_rdata = {29'h00000000, irq_status};
            end else if (ADDR == `REG_IRQ_MASK) begin
                next_rdata = {29'h00000000, irq_mask};
            end
        end
    end

    // read data stand for the one cycle after the strobe only
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            RDATA <= 32'h00000000;
        end else begin
            RDATA <= next_rdata;
        end
    end

    // edge history for interrupt events
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            temp_prev  <= 1'b0;
            cmp_prev   <= '0;
            alarm_prev <= '0;
        end else begin
            temp_prev  <= live_overtemp_flag;
            cmp_prev   <= {cmp_high, cmp_low};
            alarm_prev <= {guard_alarm, clamp_alarm};
        end
    end

    assign irq_event[`IRQ_TEMP_BIT]  = live_overtemp_flag && !temp_prev;
    assign irq_event[`IRQ_CMP_BIT]   = ({cmp_high, cmp_low} != cmp_prev);
    assign irq_event[`IRQ_ALARM_BIT] = |({guard_alarm, clamp_alarm} & ~alarm_prev);

    // sticky interrupt status, cleared by its read; a new event beats the clear
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_status <= '0;
        end else if (RD && ADDR == `REG_IRQ_STATUS) begin
            irq_status <= irq_event;
        end else begin
            irq_status <= irq_status | irq_event;
        end
    end

    // interrupt mask
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_mask <= '0;
        end else if (WR && ADDR == `REG_IRQ_MASK) begin
            irq_mask <= WDATA[`IRQ_WIDTH-1:0];
        end
    end

    // registered output trails the status by one cycle to keep outputs on flops
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(irq_status & irq_mask);
        end
    end

    assign FORCE_INPUT_SOURCE     = force_input_source;
    assign CURRENT_CLAMP_ENABLED  = current_clamp_enabled;
    assign COMPARATOR_OUT_ENABLED = comparator_out_enabled;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    sticky_set_a: assert property (
        live_overtemp_flag |=> sticky_overtemp_flag
    ) else $error("sticky overtemperature flag missed an event");

    sticky_hold_a: assert property (
        sticky_overtemp_flag && !clear_write |=> sticky_overtemp_flag
    ) else $error("sticky overtemperature flag dropped without clear");

    sticky_clear_a: assert property (
        clear_write && !live_overtemp_flag |=> !sticky_overtemp_flag
    ) else $error("sticky overtemperature flag not cleared");

    clamp_last_a: assert property (
        sys_write |=> current_clamp_enabled == {4{$past(WDATA[`CLAMP_EN_BIT])}}
    ) else $error("system clamp write not taken");

    cmp_en_last_a: assert property (
        ch_write |=> comparator_out_enabled[$past(ch_index)] == $past(WDATA[`CMP_OUT_EN_BIT])
    ) else $error("channel comparator enable write not taken");

    chan_word_a: assert property (
        RD && ADDR == `REG_RB_DATA && rb_select[3:2] == 2'b00
        |=> RDATA[23:22] == 2'b00 && RDATA[4:0] == 5'h00
            && RDATA[14:13] == $past(measure_select[rb_select[1:0]])
    ) else $error("channel readback word malformed");

    chan_temp_a: assert property (
        RD && ADDR == `REG_RB_DATA && rb_select[3:2] == 2'b00
        |=> RDATA[6:5] == {$past(sticky_overtemp_flag), $past(live_overtemp_flag)}
    ) else $error("temperature alarm missing from channel word");

    cmp_word_a: assert property (
        RD && ADDR == `REG_RB_DATA && rb_select[3:2] == 2'b01
        |=> RDATA[23:22] == 2'b01 && RDATA[13:0] == 14'h0000
            && RDATA[21] == $past(cmp_low[0]) && RDATA[14] == $past(cmp_high[3])
    ) else $error("comparator readback word malformed");

    rdata_idle_a: assert property (
        !$past(RD) |-> RDATA == 32'h00000000
    ) else $error("read data present without a read");

    force_bit_a: assert property (
        RD && ADDR == `REG_RB_DATA && rb_select[3:2] == 2'b00
        |=> RDATA[`FORCE_IN_BIT] == $past(force_input_source[rb_select[1:0]])
    ) else $error("force input source wrong in channel word");

    sys_lines_a: assert property (
        RD && ADDR == `REG_RB_DATA && rb_select[3:2] == 2'b00
        |=> RDATA[11:10] == {$past(system_force_switched[rb_select[1:0]]),
                             $past(system_sense_switched[rb_select[1:0]])}
    ) else $error("system force or sense bit wrong in channel word");

    clamp_bit_a: assert property (
        RD && ADDR == `REG_RB_DATA && rb_select[3:2] == 2'b00
        |=> RDATA[`CLAMP_EN_BIT] == $past(current_clamp_enabled[rb_select[1:0]])
    ) else $error("clamp enable wrong in channel word");

    cmp_en_bit_a: assert property (
        RD && ADDR == `REG_RB_DATA && rb_select[3:2] == 2'b00
        |=> RDATA[`CMP_OUT_EN_BIT] == $past(comparator_out_enabled[rb_select[1:0]])
    ) else $error("comparator enable wrong in channel word");

    volt_bit_a: assert property (
        RD && ADDR == `REG_RB_DATA && rb_select[3:2] == 2'b00
        |=> RDATA[`CMP_VOLT_BIT] == $past(compare_voltage[rb_select[1:0]])
    ) else $error("compare voltage bit wrong in channel word");

    clamp_chan_a: assert property (
        ch_write |=> current_clamp_enabled[$past(ch_index)] == $past(WDATA[`CLAMP_EN_BIT])
    ) else $error("channel clamp write not taken");

    cmp_en_sys_a: assert property (
        sys_write |=> comparator_out_enabled == {4{$past(WDATA[`CMP_OUT_EN_BIT])}}
    ) else $error("system comparator enable write not taken");

    cmp_track_a: assert property (
        RD && ADDR == `REG_RB_DATA && rb_select[3:2] == 2'b01
        |=> RDATA[19] == $past(cmp_low[1]) && RDATA[16] == $past(cmp_high[2])
    ) else $error("comparator bit does not follow its pin");

    alarm_word_a: assert property (
        RD && ADDR == `REG_RB_DATA && rb_select[3:2] == 2'b11
        |=> RDATA[23:20] == {2'b11, $past(sticky_overtemp_flag), $past(live_overtemp_flag)}
            && RDATA[19] == $past(sticky_guard[0]) && RDATA[10] == $past(clamp_alarm[0])
    ) else $error("alarm readback word malformed");

    ro_write_a: assert property (
        WR && ADDR == `REG_RB_DATA |=> $stable(rb_select) && $stable(irq_mask)
    ) else $error("write to readback data changed state");

endmodule // pmu_status_readback

`default_nettype wire

// ---- dv/pmu_pins_model.sv ----
// behavioural model of the comparator, temperature and alarm pins feeding the block
`timescale 1ns/1ps
`default_nettype none

module pmu_pins_model (
    input  wire logic        clk,          // system clock
    input  wire logic        rst_n,        // reset, active low
    input  wire logic        req_valid,    // new pin levels offered
    input  wire logic [16:0] req_pins,     // {guard, clamp, overtemp, high, low}
    output logic      [3:0]  cmp_low,      // low comparator outputs
    output logic      [3:0]  cmp_high,     // high comparator outputs
    output logic             overtemp,     // junction above alarm level
    output logic      [3:0]  clamp_alarm,  // per-channel clamp alarm
    output logic      [3:0]  guard_alarm   // per-channel guard alarm
);
    // levels move just after an edge; the block must synchronise them itself
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {guard_alarm, clamp_alarm, overtemp, cmp_high, cmp_low} <= 17'h00000;
        end else if (req_valid) begin
            {guard_alarm, clamp_alarm, overtemp, cmp_high, cmp_low} <= req_pins;
        end
    end
endmodule // pmu_pins_model

`default_nettype wire

// ---- dv/pmu_status_readback_bench.sv ----
// random and corner-case bench of the status readback block
`include "pmu_status_readback_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module pmu_status_readback_bench;
    logic        clk;
    logic        rst_n;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        irq;
    logic [3:0]  force_src;
    logic [3:0]  clamp_en;
    logic [3:0]  cmp_en;
    logic [3:0]  cmp_low;
    logic [3:0]  cmp_high;
    logic        overtemp;
    logic [3:0]  clamp_alarm;
    logic [3:0]  guard_alarm;
    logic        pin_valid;
    logic [16:0] pin_req;
    logic [16:0] lvl;
    logic [23:0] ctrl [4];
    logic [1:0]  sys;
    logic [31:0] got;
    int          n_errors;
    int          checks_done;
    int          cycles;

    pmu_status_readback dut (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .CMP_LOW(cmp_low), .CMP_HIGH(cmp_high), .OVERTEMP(overtemp),
        .CLAMP_ALARM(clamp_alarm), .GUARD_ALARM(guard_alarm), .IRQ(irq),
        .FORCE_INPUT_SOURCE(force_src), .CURRENT_CLAMP_ENABLED(clamp_en),
        .COMPARATOR_OUT_ENABLED(cmp_en));

    pmu_pins_model pins (.clk(clk), .rst_n(rst_n), .req_valid(pin_valid), .req_pins(pin_req),
        .cmp_low(cmp_low), .cmp_high(cmp_high), .overtemp(overtemp),
        .clamp_alarm(clamp_alarm), .guard_alarm(guard_alarm));

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // hang guard, well above the few hundred cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            complete_run();
        end
    end

    // channel readback word from the written fields and the temperature flags
    function automatic logic [31:0] chan_word(logic [23:0] f, logic s, logic l);
        return {8'h00, 2'b00, 7'h00, f[14:7], s, l, 5'h00};
    endfunction

    // comparator readback word, low/high pairs from channel 0 down
    function automatic logic [31:0] cmp_word(logic [3:0] lo, logic [3:0] hi);
        logic [31:0] w;
        w = 32'h0040_0000;
        for (int i = 0; i < 4; i++) begin
            w[21-2*i] = lo[i];
            w[20-2*i] = hi[i];
        end
        return w;
    endfunction

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [31:0] exp, input string name);
        logic [31:0] d;
        rd_reg(a, d);
        check(name, exp, d);
    endtask

    // pins change, then enough cycles for the two-flop synchronisers
    task automatic set_pins(input logic [16:0] v);
        @(posedge clk);
        pin_valid <= 1'b1;
        pin_req <= v;
        @(posedge clk);
        pin_valid <= 1'b0;
        repeat (5) @(posedge clk);
    endtask

    task automatic verify_channels(input logic s, input logic l);
        for (int c = 0; c < 4; c++) begin
            wr_reg(`REG_RB_SELECT, 32'(c));
            rd_check(`REG_RB_DATA, chan_word(ctrl[c], s, l), "channel word");
            check("pin outputs", {29'h0, ctrl[c][12], ctrl[c][9], ctrl[c][8]},
                  {29'h0, force_src[c], clamp_en[c], cmp_en[c]});
        end
    endtask

    task automatic complete_run();
        $display("checks %0d, errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        pin_valid = 1'b0;
        pin_req = 17'h00000;
        n_errors = 0;
        checks_done = 0;
        cycles = 0;
        void'($urandom(83));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        // reset state: measure output high impedance, everything else clear
        rd_check(`REG_RB_SELECT, 32'h0, "select reset");
        rd_check(`REG_RB_DATA, 32'h0000_6000, "ch0 word reset");
        check("outputs reset", 32'h0, {20'h0, force_src, clamp_en, cmp_en});
        // random channel fields; first pass puts every measure code on some channel
        for (int p = 0; p < 6; p++) begin
            for (int c = 0; c < 4; c++) begin
                ctrl[c] = 24'($urandom) & 24'h007F80;
                if (p == 0) ctrl[c][14:13] = 2'(c);
                wr_reg(`REG_CH_CTRL0 + 8'(4*c), 32'(ctrl[c]));
            end
            verify_channels(1'b0, 1'b0);
        end
        // system-wide and per-channel writes, the later one wins both ways
        sys = 2'($urandom);
        wr_reg(`REG_CH_CTRL0 + 8'h04, 32'(ctrl[1]) ^ 32'h300);
        wr_reg(`REG_SYS_CTRL, {22'h0, sys, 8'h00});
        for (int c = 0; c < 4; c++) ctrl[c][9:8] = sys;
        ctrl[2][9:8] = ~sys;
        wr_reg(`REG_CH_CTRL0 + 8'h08, 32'(ctrl[2]));
        verify_channels(1'b0, 1'b0);
        // comparator word tracks the pins; writes to the data place are ignored
        wr_reg(`REG_IRQ_MASK, 32'h7);
        for (int p = 0; p < 4; p++) begin
            lvl = (p == 0) ? 17'h000FF : {9'h000, 8'($urandom)};
            set_pins(lvl);
            if (p == 0) begin
                check("irq on change", 32'h1, {31'h0, irq});
                rd_reg(`REG_IRQ_STATUS, got);
                check("cmp event", 32'h2, got & 32'h2);
                repeat (2) @(posedge clk);
                #1;
                check("irq cleared", 32'h0, {31'h0, irq});
            end
            wr_reg(`REG_RB_DATA, 32'hFFFF_FFFF);
            wr_reg(`REG_RB_SELECT, 32'h0040_0000);
            rd_check(`REG_RB_DATA, cmp_word(lvl[3:0], lvl[7:4]), "cmp word");
        end
        // over-temperature with clamp and guard alarms on channel 0, first masked
        wr_reg(`REG_IRQ_MASK, 32'h0);
        set_pins(17'h02300);
        check("masked irq", 32'h0, {31'h0, irq});
        wr_reg(`REG_IRQ_MASK, 32'h1);
        @(posedge clk);
        #1;
        check("unmasked irq", 32'h1, {31'h0, irq});
        rd_check(`REG_IRQ_MASK, 32'h1, "mask readback");
        rd_reg(`REG_IRQ_STATUS, got);
        check("temp and alarm events", 32'h5, got & 32'h5);
        repeat (2) @(posedge clk);
        #1;
        check("irq after read", 32'h0, {31'h0, irq});
        verify_channels(1'b1, 1'b1);
        wr_reg(`REG_RB_SELECT, 32'h00C0_0000);
        rd_check(`REG_RB_DATA, 32'h00FC_0C00, "alarm word");
        set_pins(17'h00000);
        verify_channels(1'b1, 1'b0);
        wr_reg(`REG_CH_CTRL0 + 8'h0C, 32'(ctrl[3]) | 32'h40);
        verify_channels(1'b0, 1'b0);
        wr_reg(`REG_RB_SELECT, 32'h00C0_0000);
        rd_check(`REG_RB_DATA, 32'h00C0_0000, "alarm cleared");
        // reserved word type, select readback and an unmapped address
        wr_reg(`REG_RB_SELECT, 32'h0080_0003);
        rd_check(`REG_RB_SELECT, 32'h0080_0003, "select readback");
        rd_check(`REG_RB_DATA, 32'h0080_0000, "reserved word");
        rd_check(8'h40, 32'h0, "unmapped read");
        complete_run();
    end
endmodule // pmu_status_readback_bench

`default_nettype wire
